// [common/dma_pkg.sv]
// Constants, field layouts and carrier types for the peripheral DMA channel engine
package dma_pkg;

  // Register byte offsets on the software port
  localparam int REG_ADDR_W = 8;
  localparam logic [REG_ADDR_W-1:0] OFS_TABLE_BASE  = 8'h08;
  localparam logic [REG_ADDR_W-1:0] OFS_BURST_SET   = 8'h18;
  localparam logic [REG_ADDR_W-1:0] OFS_BURST_CLR   = 8'h1C;
  localparam logic [REG_ADDR_W-1:0] OFS_MASK_SET    = 8'h20;
  localparam logic [REG_ADDR_W-1:0] OFS_MASK_CLR    = 8'h24;
  localparam logic [REG_ADDR_W-1:0] OFS_ENABLE_SET  = 8'h28;
  localparam logic [REG_ADDR_W-1:0] OFS_ENABLE_CLR  = 8'h2C;
  localparam logic [REG_ADDR_W-1:0] OFS_ALT_SET     = 8'h30;
  localparam logic [REG_ADDR_W-1:0] OFS_ALT_CLR     = 8'h34;
  localparam logic [REG_ADDR_W-1:0] OFS_PRIO_SET    = 8'h38;
  localparam logic [REG_ADDR_W-1:0] OFS_PRIO_CLR    = 8'h3C;

  // Reset values
  localparam logic [31:0] RST_TABLE_BASE = 32'h0000_0000;
  localparam logic        RST_CHAN_BIT   = 1'b0;
  localparam logic [31:0] TABLE_BASE_MASK = 32'hFFFF_FC00;

  // Control table layout
  localparam logic [31:0] ALT_TABLE_OFFSET = 32'h0000_0200;
  localparam int          STRUCT_SHIFT     = 4;
  localparam logic [31:0] WORD_SRC_END     = 32'h0000_0000;
  localparam logic [31:0] WORD_DST_END     = 32'h0000_0004;
  localparam logic [31:0] WORD_CTL         = 32'h0000_0008;

  // Field codes of the channel control word
  localparam logic [1:0] STEP_NONE      = 2'h3;
  localparam logic [1:0] WIDTH_BYTE     = 2'h0;
  localparam logic [2:0] MODE_STOPPED   = 3'h0;
  localparam logic [2:0] MODE_BASIC     = 3'h1;
  localparam logic [2:0] MODE_PINGPONG  = 3'h3;
  localparam logic [3:0] ARB_CODE_MAX   = 4'hA;
  localparam int         COUNT_W        = 10;
  localparam int         UNIT_W         = 11;

  // Layout of channel_transfer_control_word
  typedef struct packed {
    logic [1:0]         destination_step_code;
    logic [1:0]         destination_item_width;
    logic [1:0]         source_step_code;
    logic [1:0]         source_item_width;
    logic [5:0]         reserved;
    logic [3:0]         rearbitration_count_code;
    logic [COUNT_W-1:0] item_count_minus_one;
    logic               next_burst_only_flag;
    logic [2:0]         transfer_operating_mode;
  } ctl_word_t;

  // System memory master request, one cycle per access
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [1:0]  width;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mem_req_t;

  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_FSRC = 4'h1,
    S_FDST = 4'h2,
    S_FCTL = 4'h3,
    S_FCAP = 4'h4,
    S_RD   = 4'h5,
    S_RDW  = 4'h6,
    S_WR   = 4'h7,
    S_WB   = 4'h8
  } state_t;

endpackage : dma_pkg

// [core/dma_channel_basic_pingpong.sv]
// Peripheral DMA channel engine with basic and ping-pong modes
//
// Notes on behaviour
// R1: Software loads end pointers with the last address of the transfer, inclusive.
// R2: Destination step code 3 keeps destination at its end pointer.
// R3: Source step code 3 keeps source at its end pointer.
// R4: Code 0 means byte items and byte address stepping.
// R5: Rearbitration code sets items per unit: code 2 gives 4, code 3 gives 8.
// R6: Item count field holds items minus one.
// R7: Mode 1 is basic, 3 is ping-pong, 0 is stopped.
// R8: A burst request moves one full rearbitration unit of items.
// R9: A single request moves exactly one item.
// R10: Burst-only set makes the channel ignore single requests.
// R11: Burst-only clear lets single and burst requests both be served.
// R12: Unmask write lets the channel's requests be recognised.
// R13: Alternate clear selects the primary structure for the next transfer.
// R14: Priority set gives high priority, priority clear returns default.
// R15: An enabled channel transfers on each request until its count is spent.
// R16: Basic completion disables channel and writes stopped mode to memory.
// R17: Enable bit reads one while active and clears itself on completion.
// R18: Primary structure at base plus 16 per channel, alternate 0x200 higher.
// R19: Source end, destination end, control word are consecutive words.
// R20: Ping-pong primary completion stops it, switches to alternate, signals done.
// R21: Completion is signalled on the channel's own peripheral done line.
// R22: Software finds the stopped structure, drains it and rewrites its control word.
// R23: Alternate completion returns to primary; stopped primary then stops the channel.
//
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module dma_channel_basic_pingpong
  import dma_pkg::*;
#(
  parameter int CHANNELS = 32
) (
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  input  wire logic [REG_ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [31:0]           reg_rdata,
  input  wire logic [CHANNELS-1:0]   single_req,
  input  wire logic [CHANNELS-1:0]   burst_req,
  output logic      [CHANNELS-1:0]   req_ack,
  output logic      [CHANNELS-1:0]   xfer_done,
  output mem_req_t                   mem_req,
  input  wire logic [31:0]           mem_rdata
);

  localparam int CW = (CHANNELS > 1) ? $clog2(CHANNELS) : 1;

  state_t              state_q;
  logic [31:0]         base_q;
  logic [CHANNELS-1:0] ena_q;
  logic [CHANNELS-1:0] burst_only_q;
  logic [CHANNELS-1:0] mask_q;
  logic [CHANNELS-1:0] alt_q;
  logic [CHANNELS-1:0] prio_q;
  logic [CW-1:0]       ch_q;
  logic                alt_cur_q;
  logic                burst_unit_q;
  logic                pp_q;
  logic                complete_q;
  logic [31:0]         src_end_q;
  logic [31:0]         dst_end_q;
  logic [31:0]         data_q;
  ctl_word_t           ctl_q;
  logic [UNIT_W-1:0]   limit_q;
  logic [UNIT_W-1:0]   moved_q;

  logic [CHANNELS-1:0] elig;
  logic [CHANNELS-1:0] pool;
  logic [CHANNELS-1:0] ch_onehot;
  logic [CW-1:0]       grant_ch;
  logic                grant;
  ctl_word_t           ctl_live;
  logic                mode_ok;
  logic                last_item;
  logic                unit_full;
  logic [CHANNELS-1:0] hw_ena_clr;
  logic [CHANNELS-1:0] hw_alt_tog;

  function automatic logic [CW-1:0] first_set(input logic [CHANNELS-1:0] v);
    logic [CW-1:0] idx;
    idx = '0;
    for (int i = CHANNELS - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = CW'(i);
      end
    end
    return idx;
  endfunction : first_set

  // Address of item n counted back from the inclusive end pointer
  function automatic logic [31:0] item_addr(input logic [31:0] end_ptr,
                                            input logic [COUNT_W-1:0] n,
                                            input logic [1:0] step);
    logic [31:0] back;
    back = {{(32-COUNT_W){1'b0}}, n} << step;
    if (step == STEP_NONE) begin                                  // [R2] [R3]
      return end_ptr;
    end
    return end_ptr - back;                                         // [R4] [R6]
  endfunction : item_addr

  function automatic logic [31:0] struct_addr(input logic [31:0] base, input logic alt,
                                              input logic [CW-1:0] ch, input logic [31:0] word);
    logic [31:0] ofs;
    ofs = (32'(ch) << STRUCT_SHIFT) + (alt ? ALT_TABLE_OFFSET : 32'h0000_0000); // [R18]
    return base + ofs + word;                                      // [R19]
  endfunction : struct_addr

  function automatic logic [UNIT_W-1:0] unit_limit(input logic [3:0] code, input logic burst);
    logic [3:0] c;
    c = (code > ARB_CODE_MAX) ? ARB_CODE_MAX : code;
    if (!burst) begin
      return UNIT_W'(1);                                           // [R9]
    end
    return UNIT_W'(1) << c;                                        // [R5] [R8]
  endfunction : unit_limit

  // Eligibility and fixed-order arbitration, high priority first
  // A request still high in its acknowledge cycle is stale and must not be served again
  assign elig      = ena_q & ~mask_q & ~req_ack                    // [R12] [R15]
                     & (burst_req | (single_req & ~burst_only_q)); // [R10]
  assign pool      = (|(elig & prio_q)) ? (elig & prio_q) : elig;                  // [R14]
  assign grant_ch  = first_set(pool);
  assign grant     = (state_q == S_IDLE) && (|elig);
  assign ch_onehot = CHANNELS'(1) << ch_q;

  assign ctl_live  = (state_q == S_FCAP) ? ctl_word_t'(mem_rdata) : ctl_q;
  assign mode_ok   = (ctl_live.transfer_operating_mode == MODE_BASIC) ||
                     (ctl_live.transfer_operating_mode == MODE_PINGPONG);          // [R7] [R23]
  assign last_item = (ctl_q.item_count_minus_one == '0);
  assign unit_full = ((moved_q + UNIT_W'(1)) == limit_q);

  assign hw_ena_clr = ((state_q == S_FCAP && !mode_ok) ||
                       (state_q == S_WB && complete_q && !pp_q)) ? ch_onehot : '0;  // [R16] [R17]
  assign hw_alt_tog = (state_q == S_WB && complete_q && pp_q) ? ch_onehot : '0;    // [R20] [R23]

  // Software register writes
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      base_q <= RST_TABLE_BASE;
    end else if (reg_wr && reg_addr == OFS_TABLE_BASE) begin
      base_q <= reg_wdata & TABLE_BASE_MASK;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ena_q <= {CHANNELS{RST_CHAN_BIT}};
    end else begin
      // Software set wins over a completion clear in the same cycle
      ena_q <= (ena_q & ~hw_ena_clr // [R15] [R17]
                & ~((reg_wr && reg_addr == OFS_ENABLE_CLR) ? reg_wdata[CHANNELS-1:0] : '0))
               | ((reg_wr && reg_addr == OFS_ENABLE_SET) ? reg_wdata[CHANNELS-1:0] : '0);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      burst_only_q <= {CHANNELS{RST_CHAN_BIT}};
    end else if (reg_wr && reg_addr == OFS_BURST_SET) begin
      burst_only_q <= burst_only_q | reg_wdata[CHANNELS-1:0];     // [R10]
    end else if (reg_wr && reg_addr == OFS_BURST_CLR) begin
      burst_only_q <= burst_only_q & ~reg_wdata[CHANNELS-1:0];    // [R11]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mask_q <= {CHANNELS{RST_CHAN_BIT}};
    end else if (reg_wr && reg_addr == OFS_MASK_SET) begin
      mask_q <= mask_q | reg_wdata[CHANNELS-1:0];
    end else if (reg_wr && reg_addr == OFS_MASK_CLR) begin
      mask_q <= mask_q & ~reg_wdata[CHANNELS-1:0];                // [R12]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      alt_q <= {CHANNELS{RST_CHAN_BIT}};
    end else if (reg_wr && reg_addr == OFS_ALT_SET) begin
      alt_q <= (alt_q ^ hw_alt_tog) | reg_wdata[CHANNELS-1:0];
    end else if (reg_wr && reg_addr == OFS_ALT_CLR) begin
      alt_q <= (alt_q ^ hw_alt_tog) & ~reg_wdata[CHANNELS-1:0];   // [R13]
    end else begin
      alt_q <= alt_q ^ hw_alt_tog;                                 // [R20]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prio_q <= {CHANNELS{RST_CHAN_BIT}};
    end else if (reg_wr && reg_addr == OFS_PRIO_SET) begin
      prio_q <= prio_q | reg_wdata[CHANNELS-1:0];                 // [R14]
    end else if (reg_wr && reg_addr == OFS_PRIO_CLR) begin
      prio_q <= prio_q & ~reg_wdata[CHANNELS-1:0];                // [R14]
    end
  end

  // Read data stands in the cycle after the read strobe only
  always_ff @(posedge ref_clk) begin
    if (rst || !reg_rd) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= 32'h0000_0000;
      case (reg_addr)
        OFS_TABLE_BASE: reg_rdata <= base_q;
        OFS_BURST_SET:  reg_rdata[CHANNELS-1:0] <= burst_only_q;
        OFS_MASK_SET:   reg_rdata[CHANNELS-1:0] <= mask_q;
        OFS_ENABLE_SET: reg_rdata[CHANNELS-1:0] <= ena_q;          // [R17]
        OFS_ALT_SET:    reg_rdata[CHANNELS-1:0] <= alt_q;
        OFS_PRIO_SET:   reg_rdata[CHANNELS-1:0] <= prio_q;
        default:        reg_rdata <= 32'h0000_0000;
      endcase
    end
  end

  // Channel sequencer: fetch structure, move items, write control word back
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q      <= S_IDLE;
      ch_q         <= '0;
      alt_cur_q    <= 1'b0;
      burst_unit_q <= 1'b0;
      pp_q         <= 1'b0;
      complete_q   <= 1'b0;
      src_end_q    <= 32'h0000_0000;
      dst_end_q    <= 32'h0000_0000;
      data_q       <= 32'h0000_0000;
      ctl_q        <= '0;
      limit_q      <= '0;
      moved_q      <= '0;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (grant) begin
            ch_q         <= grant_ch;
            alt_cur_q    <= alt_q[grant_ch];
            burst_unit_q <= burst_req[grant_ch];                   // [R8] [R9]
            complete_q   <= 1'b0;
            moved_q      <= '0;
            state_q      <= S_FSRC;
          end
        end
        S_FSRC: state_q <= S_FDST;
        S_FDST: begin
          src_end_q <= mem_rdata;
          state_q   <= S_FCTL;
        end
        S_FCTL: begin
          dst_end_q <= mem_rdata;
          state_q   <= S_FCAP;
        end
        S_FCAP: begin
          ctl_q   <= ctl_live;
          pp_q    <= (ctl_live.transfer_operating_mode == MODE_PINGPONG);
          limit_q <= unit_limit(ctl_live.rearbitration_count_code, burst_unit_q);
          state_q <= mode_ok ? S_RD : S_IDLE;
        end
        S_RD:  state_q <= S_RDW;
        S_RDW: begin
          data_q  <= mem_rdata;
          state_q <= S_WR;
        end
        S_WR: begin
          moved_q <= moved_q + UNIT_W'(1);
          if (last_item) begin
            ctl_q.transfer_operating_mode <= MODE_STOPPED;         // [R16] [R20]
            complete_q                    <= 1'b1;
            state_q                       <= S_WB;
          end else begin
            ctl_q.item_count_minus_one <= ctl_q.item_count_minus_one - COUNT_W'(1);
            state_q                    <= unit_full ? S_WB : S_RD; // [R5] [R8]
          end
        end
        S_WB:    state_q <= S_IDLE;
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // Memory requests, each held for one cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mem_req <= '0;
    end else begin
      mem_req <= '0;
      case (state_q)
        S_IDLE: begin
          if (grant) begin
            mem_req.rd   <= 1'b1;
            mem_req.addr <= struct_addr(base_q, alt_q[grant_ch], grant_ch, WORD_SRC_END);
          end
        end
        S_FSRC: begin
          mem_req.rd   <= 1'b1;
          mem_req.addr <= struct_addr(base_q, alt_cur_q, ch_q, WORD_DST_END);
        end
        S_FDST: begin
          mem_req.rd   <= 1'b1;
          mem_req.addr <= struct_addr(base_q, alt_cur_q, ch_q, WORD_CTL);
        end
        S_FCAP: begin
          if (mode_ok) begin
            mem_req.rd    <= 1'b1;
            mem_req.width <= ctl_live.source_item_width;
            mem_req.addr  <= item_addr(src_end_q, ctl_live.item_count_minus_one,
                                       ctl_live.source_step_code);
          end
        end
        S_RDW: begin
          mem_req.wr    <= 1'b1;
          mem_req.width <= ctl_q.destination_item_width;
          mem_req.wdata <= mem_rdata;
          mem_req.addr  <= item_addr(dst_end_q, ctl_q.item_count_minus_one,
                                     ctl_q.destination_step_code);
        end
        S_WR: begin
          if (last_item || unit_full) begin
            mem_req.wr   <= 1'b1;
            mem_req.addr <= struct_addr(base_q, alt_cur_q, ch_q, WORD_CTL);
            if (last_item) begin
              mem_req.wdata <= {ctl_q[31:3], MODE_STOPPED};         // [R16] [R20]
            end else begin
              mem_req.wdata <= {ctl_q[31:14], ctl_q.item_count_minus_one - COUNT_W'(1),
                                ctl_q[3:0]};
            end
          end else begin
            mem_req.rd    <= 1'b1;
            mem_req.width <= ctl_q.source_item_width;
            mem_req.addr  <= item_addr(src_end_q, ctl_q.item_count_minus_one - COUNT_W'(1),
                                       ctl_q.source_step_code);
          end
        end
        default: mem_req <= '0;
      endcase
    end
  end

  // Peripheral handshake: acknowledge per unit, done per completed structure
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      req_ack   <= '0;
      xfer_done <= '0;
    end else begin
      req_ack   <= (state_q == S_WB || (state_q == S_FCAP && !mode_ok)) ? ch_onehot : '0;
      xfer_done <= (state_q == S_WB && complete_q) ? ch_onehot : '0;         // [R21]
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  AST_DST_FIXED: assert property ( // [R2]
    mem_req.wr && $past(state_q) == S_RDW && ctl_q.destination_step_code == STEP_NONE
    |-> mem_req.addr == dst_end_q)
    else $error("fixed destination moved away from its end pointer");

  AST_SRC_FIXED: assert property ( // [R3]
    state_q == S_RD && ctl_q.source_step_code == STEP_NONE |-> mem_req.addr == src_end_q)
    else $error("fixed source moved away from its end pointer");

  AST_BYTE_STEP: assert property ( // [R4]
    mem_req.wr && $past(state_q) == S_RDW && ctl_q.destination_step_code == WIDTH_BYTE
    |-> mem_req.addr == dst_end_q - 32'(ctl_q.item_count_minus_one))
    else $error("byte step address wrong");

  AST_UNIT_LIMIT: assert property ( // [R5]
    state_q == S_RD && burst_unit_q && ctl_q.rearbitration_count_code == 4'h3
    |-> limit_q == UNIT_W'(8))
    else $error("rearbitration unit size wrong");

  AST_SINGLE_ONE: assert property ( // [R9]
    state_q == S_WR && !burst_unit_q |=> state_q == S_WB)
    else $error("single request moved more than one item");

  AST_BURST_ONLY: assert property ( // [R10]
    grant && burst_only_q[grant_ch] |-> burst_req[grant_ch])
    else $error("burst-only channel served on single request");

  AST_MASKED: assert property ( // [R12]
    grant |-> !mask_q[grant_ch] && ena_q[grant_ch])
    else $error("masked or disabled channel granted");

  AST_PRIORITY: assert property ( // [R14]
    grant && !prio_q[grant_ch] |-> (elig & prio_q) == '0)
    else $error("default channel beat an eligible high priority channel");

  AST_BASIC_DONE: assert property ( // [R16]
    state_q == S_WB && complete_q && !pp_q && !(reg_wr && reg_addr == OFS_ENABLE_SET)
    |=> !ena_q[ch_q] && xfer_done[ch_q])
    else $error("basic completion left channel enabled or unsignalled");

  AST_PP_SWITCH: assert property ( // [R20]
    state_q == S_WB && complete_q && pp_q && !(reg_wr && reg_addr[7:4] == 4'h3)
    |=> alt_q[ch_q] != $past(alt_q[ch_q]) && ena_q[ch_q] && state_q == S_IDLE)
    else $error("ping-pong completion did not switch structure");

  AST_ENABLE_READ: assert property ( // [R17]
    reg_rd && reg_addr == OFS_ENABLE_SET |=> reg_rdata[CHANNELS-1:0] == $past(ena_q))
    else $error("enable status readback wrong");

  COV_BURST_UNIT: cover property (state_q == S_WB && burst_unit_q && !complete_q);
  COV_BASIC_END:  cover property (state_q == S_WB && complete_q && !pp_q);
  COV_PP_END:     cover property (state_q == S_WB && complete_q && pp_q);

endmodule : dma_channel_basic_pingpong

`default_nettype wire

// [tb/periph_model.sv]
// Peripheral with request lines plus byte-wide system memory seen by the DMA engine
`timescale 1ns/100ps
`default_nettype none

module periph_model
  import dma_pkg::*;
#(
  parameter int          CH      = 16,
  parameter logic [11:0] TX_ADDR = 12'hF00
) (
  input  wire logic          ref_clk,
  input  wire logic          rst,
  input  wire logic [CH-1:0] arm_single,
  input  wire logic [CH-1:0] arm_burst,
  input  wire logic [CH-1:0] req_ack,
  input  wire mem_req_t      mem_req,
  output logic      [31:0]   mem_rdata,
  output logic      [CH-1:0] single_req,
  output logic      [CH-1:0] burst_req,
  output logic      [7:0]    tx_hits,
  output logic      [7:0]    tx_last
);
  logic [7:0]  mem [0:4095];
  logic [11:0] a;

  assign a = mem_req.addr[11:0];

  // Requests stay up until the engine acknowledges the unit
  always @(posedge ref_clk) begin
    if (rst) begin
      single_req <= '0;
      burst_req  <= '0;
    end else begin
      single_req <= (single_req | arm_single) & ~req_ack;
      burst_req  <= (burst_req | arm_burst) & ~req_ack;
    end
  end

  // Read data stand one cycle; otherwise the bus toggles so stale data never match
  always @(posedge ref_clk) begin
    if (rst) begin
      mem_rdata <= 32'h0000_0000;
    end else if (mem_req.rd) begin
      mem_rdata <= {mem[a + 12'h3], mem[a + 12'h2], mem[a + 12'h1], mem[a]};
    end else begin
      mem_rdata <= ~mem_rdata;
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      tx_hits <= 8'h00;
      tx_last <= 8'h00;
    end else if (mem_req.wr) begin
      mem[a] <= mem_req.wdata[7:0];
      if (mem_req.width != 2'h0) begin
        mem[a + 12'h1] <= mem_req.wdata[15:8];
      end
      if (mem_req.width > 2'h1) begin
        mem[a + 12'h2] <= mem_req.wdata[23:16];
        mem[a + 12'h3] <= mem_req.wdata[31:24];
      end
      if (a == TX_ADDR) begin
        tx_hits <= tx_hits + 8'h01;
        tx_last <= mem_req.wdata[7:0];
      end
    end
  end
endmodule : periph_model

`default_nettype wire

// [tb/tb.sv]
// Register-level test of the DMA channel engine in basic and ping-pong modes
`timescale 1ns/100ps
`default_nettype none

module tb;
  import dma_pkg::*;
  localparam int CH = 16;
  logic                  ref_clk;
  logic                  rst;
  logic [REG_ADDR_W-1:0] reg_addr;
  logic [31:0]           reg_wdata;
  logic [31:0]           reg_rdata;
  logic [31:0]           rv;
  logic                  reg_wr;
  logic                  reg_rd;
  logic [CH-1:0]         single_req;
  logic [CH-1:0]         burst_req;
  logic [CH-1:0]         req_ack;
  logic [CH-1:0]         xfer_done;
  logic [CH-1:0]         arm_single;
  logic [CH-1:0]         arm_burst;
  mem_req_t              mem_req;
  logic [31:0]           mem_rdata;
  logic [7:0]            tx_hits;
  logic [7:0]            tx_last;
  int                    mismatches;
  int                    total_checks;

  dma_channel_basic_pingpong #(.CHANNELS(CH)) u_dma_channel_basic_pingpong (
    .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .single_req(single_req),
    .burst_req(burst_req), .req_ack(req_ack), .xfer_done(xfer_done),
    .mem_req(mem_req), .mem_rdata(mem_rdata));

  periph_model #(.CH(CH)) u_periph_model (
    .ref_clk(ref_clk), .rst(rst), .arm_single(arm_single), .arm_burst(arm_burst),
    .req_ack(req_ack), .mem_req(mem_req), .mem_rdata(mem_rdata), .single_req(single_req),
    .burst_req(burst_req), .tx_hits(tx_hits), .tx_last(tx_last));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [REG_ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [REG_ADDR_W-1:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  task automatic put_word(input logic [11:0] a, input logic [31:0] w);
    for (int i = 0; i < 4; i++) u_periph_model.mem[a + 12'(i)] = w[8*i +: 8];
  endtask : put_word

  function automatic logic [31:0] get_word(input logic [11:0] a);
    return {u_periph_model.mem[a + 12'h3], u_periph_model.mem[a + 12'h2],
            u_periph_model.mem[a + 12'h1], u_periph_model.mem[a]};
  endfunction : get_word

  function automatic ctl_word_t mk(input logic [1:0] dstep, input logic [1:0] sstep,
                                   input logic [3:0] arb, input logic [9:0] cnt,
                                   input logic [2:0] mode);
    ctl_word_t c;
    c = '0;
    c.destination_step_code    = dstep;
    c.source_step_code         = sstep;
    c.rearbitration_count_code = arb;
    c.item_count_minus_one     = cnt;
    c.transfer_operating_mode  = mode;
    return c;
  endfunction : mk

  // Pulse one arm line of the peripheral for a cycle
  task automatic arm(input logic burst, input int ch);
    @(posedge ref_clk);
    if (burst) arm_burst[ch] <= 1'b1;
    else arm_single[ch] <= 1'b1;
    @(posedge ref_clk);
    arm_burst  <= '0;
    arm_single <= '0;
  endtask : arm

  // Wait for acknowledge (done=0) or completion (done=1) of one channel
  task automatic wait_pulse(input logic done, input int ch);
    for (int i = 0; i < 300; i++) begin
      @(posedge ref_clk);
      if ((done ? xfer_done[ch] : req_ack[ch]) === 1'b1) return;
    end
    mismatches++;
    $display("[FAIL] wait on channel %0d timed out", ch);
    stop_test();
  endtask : wait_pulse

  initial begin
    rst = 1'b1; reg_addr = '0; reg_wdata = '0; reg_wr = 1'b0; reg_rd = 1'b0;
    arm_single = '0; arm_burst = '0; mismatches = 0; total_checks = 0;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    rd(OFS_ENABLE_SET, rv); check("enable_reset", rv, 32'h0);
    rd(OFS_TABLE_BASE, rv); check("base_reset", rv, RST_TABLE_BASE);
    wr(OFS_TABLE_BASE, 32'h0000_0400);
    rd(OFS_TABLE_BASE, rv); check("base_rw", rv, 32'h0000_0400);
    rd(8'h44, rv); check("unmapped", rv, 32'h0);
    wr(OFS_PRIO_SET, 32'h0000_0080);
    rd(OFS_PRIO_SET, rv); check("prio_set", rv, 32'h0000_0080);
    wr(OFS_PRIO_CLR, 32'h0000_0080);
    rd(OFS_PRIO_SET, rv); check("prio_clr", rv, 32'h0);
    // Basic transmit on channel 7: four bytes to a fixed data register
    put_word(12'h800, 32'h4433_2211);
    put_word(12'h470, 32'h0000_0803);
    put_word(12'h474, 32'h0000_0F00);
    put_word(12'h478, mk(STEP_NONE, 2'h0, 4'h2, 10'h3, MODE_BASIC));
    wr(OFS_ALT_CLR, 32'h0000_0080);
    wr(OFS_MASK_CLR, 32'h0000_0080);
    wr(OFS_BURST_SET, 32'h0000_0080);
    rd(OFS_BURST_SET, rv); check("burst_only", rv, 32'h0000_0080);
    wr(OFS_ENABLE_SET, 32'h0000_0080);
    rd(OFS_ENABLE_SET, rv); check("enable_active", rv, 32'h0000_0080);
    arm(1'b0, 7);
    repeat (30) @(posedge ref_clk);
    check("single_ignored", tx_hits, 32'h0);
    arm(1'b1, 7);
    wait_pulse(1'b1, 7);
    check("burst_items", tx_hits, 32'h4);
    check("last_byte", tx_last, 32'h44);
    check("ch7_mode", get_word(12'h478) & 32'h7, 32'h0);
    rd(OFS_ENABLE_SET, rv); check("enable_cleared", rv, 32'h0);
    // Ping-pong receive on channel 8: two bytes per buffer from a fixed register
    put_word(12'hF10, 32'h0000_005A);
    put_word(12'h900, 32'h0);
    put_word(12'h910, 32'h0);
    put_word(12'h480, 32'h0000_0F10);
    put_word(12'h484, 32'h0000_0901);
    put_word(12'h488, mk(2'h0, STEP_NONE, 4'h3, 10'h1, MODE_PINGPONG));
    put_word(12'h680, 32'h0000_0F10);
    put_word(12'h684, 32'h0000_0911);
    put_word(12'h688, mk(2'h0, STEP_NONE, 4'h3, 10'h1, MODE_PINGPONG));
    wr(OFS_ALT_SET, 32'h0000_0100);
    wr(OFS_ALT_CLR, 32'h0000_0100);
    wr(OFS_BURST_CLR, 32'h0000_0100);
    wr(OFS_MASK_CLR, 32'h0000_0100);
    wr(OFS_ENABLE_SET, 32'h0000_0100);
    arm(1'b0, 8);
    wait_pulse(1'b0, 8);
    check("one_item", get_word(12'h900), 32'h0000_005A);
    arm(1'b0, 8);
    wait_pulse(1'b1, 8);
    check("buffer_a", get_word(12'h900), 32'h0000_5A5A);
    check("pri_stopped", get_word(12'h488) & 32'h7, 32'h0);
    rd(OFS_ALT_SET, rv); check("alt_active", rv, 32'h0000_0100);
    rd(OFS_ENABLE_SET, rv); check("still_enabled", rv, 32'h0000_0100);
    arm(1'b1, 8);
    wait_pulse(1'b1, 8);
    check("buffer_b", get_word(12'h910), 32'h0000_5A5A);
    check("alt_stopped", get_word(12'h688) & 32'h7, 32'h0);
    rd(OFS_ALT_SET, rv); check("back_primary", rv, 32'h0);
    arm(1'b0, 8);
    wait_pulse(1'b0, 8);
    rd(OFS_ENABLE_SET, rv); check("pp_stopped", rv, 32'h0);
    stop_test();
  end
endmodule : tb

`default_nettype wire
